// ===== design/analog_input_block.sv
// analog input processing: scaling, redundant pairs, coherence and comparators
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: single mode processes each channel independently
// R2: redundant pair on channels one-two or three-four
// R3: compare pair difference against maximum deviation
// R4: timeout in seconds before deviation counts
// R5: fault after continuous excess; return restarts timer
// R6: equal sensors share first sensor's scale
// R7: different sensors: second uses own scale
// R8: primary selection gives primary reading
// R9: redundant selection gives redundant reading
// R10: maximum selection gives greater reading
// R11: minimum selection gives lesser reading
// R12: average gives mean, used everywhere downstream; code feeds it to the first lane only, the second lane keeps its own reading
// R13: scale minimum maps to sensor lowest output
// R14: scale maximum maps to sensor highest output
// R15: linear conversion from scale endpoints
// R16: two thresholds or one window comparator
// R17: window has high, low, hysteresis; adds output
// R18: window output from measurement and stored state
// R19: out-of-window state drives output zero
// R20: in-window state drives output one
// R21: enter window below high-hyst, above low; code enters only above low+hyst
// R22: stay while below high, above low+hyst
// R23: anomaly forces configured saturation value
// R24: error output follows anomaly when enabled
module analog_input_block
  import analog_input_pkg::*;
#(
  parameter int CYCLES_PER_SEC = SEC_S * CLK_HZ
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire reg_req_type                 reg_req,
  output logic        [DATA_W-1:0]         rd_data,
  input  wire logic   [LANES-1:0]          sample_valid,
  input  wire logic   [LANES*SAMPLE_W-1:0] sample_code,
  input  wire logic   [LANES-1:0]          sensor_anomaly,
  output logic        [LANES*VALUE_W-1:0]  measurement_value,
  output logic        [LANES-1:0]          comparator_result_output,
  output logic        [LANES-1:0]          threshold2_output,
  output logic        [LANES-1:0]          error_output,
  output logic        [PAIRS-1:0]          coherence_fault
);

  // ==========================================================
  // decode helpers
  function automatic logic [2:0] lane_ofs(input logic [ADDR_W-1:0] a);
    return a[2:0];
  endfunction

  function automatic logic lane_hit(input logic [ADDR_W-1:0] a, input int l);
    return a[ADDR_W-1:3] == 5'(l);
  endfunction

  // linear map: code range of the sensor type onto smin..smax
  function automatic logic signed [VALUE_W-1:0] scale_fn(
    input logic [SAMPLE_W-1:0]       code,
    input logic [1:0]                typ,
    input logic signed [VALUE_W-1:0] smin,
    input logic signed [VALUE_W-1:0] smax);
    logic signed [63:0] d;
    logic signed [63:0] span;
    logic signed [63:0] prod;
    logic [SAMPLE_W-1:0] lo;
    logic [17:0]         recip;
    lo    = (typ == SENS_4_20) ? CODE_4MA :
            (typ == SENS_0_20) ? CODE_0MA : CODE_0V;                       // R13
    recip = (typ == SENS_4_20) ? RECIP_4_20 : RECIP_0_20;                  // R14
    d     = 64'(signed'({1'b0, code})) - 64'(signed'({1'b0, lo}));
    span  = 64'(smax) - 64'(smin);
    prod  = (d * span * 64'(signed'({1'b0, recip}))) >>> RECIP_SH;         // R15
    return VALUE_W'(64'(smin) + prod);
  endfunction

  // ==========================================================
  // register file
  lane_cfg_type                cfg_r      [LANES];
  logic signed [VALUE_W-1:0]   smin_r     [LANES];
  logic signed [VALUE_W-1:0]   smax_r     [LANES];
  logic signed [VALUE_W-1:0]   thr_hi_r   [LANES];
  logic signed [VALUE_W-1:0]   thr_lo_r   [LANES];
  logic signed [VALUE_W-1:0]   hyst_r     [LANES];
  pair_cfg_type                pcfg_r     [PAIRS];
  logic        [VALUE_W-1:0]   max_dev_r  [PAIRS];
  logic        [SEC_W-1:0]     timeout_r  [PAIRS];

  wire logic [ADDR_W-1:0] addr = reg_req.addr;
  wire logic [2:0]        ofs  = lane_ofs(reg_req.addr);

  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_lane_regs
      wire logic wr_lane = reg_req.wr && lane_hit(addr, gl);
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          cfg_r[gl]    <= LANE_CFG_RST;
          smin_r[gl]   <= 16'h0000;
          smax_r[gl]   <= 16'h0000;
          thr_hi_r[gl] <= 16'h0000;
          thr_lo_r[gl] <= 16'h0000;
          hyst_r[gl]   <= 16'h0000;
        end else if (wr_lane) begin
          case (ofs)
            OFS_CFG:       cfg_r[gl]    <= lane_cfg_type'(reg_req.wdata[LANE_CFG_W-1:0]);
            OFS_SCALE_MIN: smin_r[gl]   <= reg_req.wdata[VALUE_W-1:0];
            OFS_SCALE_MAX: smax_r[gl]   <= reg_req.wdata[VALUE_W-1:0];
            OFS_THR_HI:    thr_hi_r[gl] <= reg_req.wdata[VALUE_W-1:0];
            OFS_THR_LO:    thr_lo_r[gl] <= reg_req.wdata[VALUE_W-1:0];
            OFS_HYST:      hyst_r[gl]   <= reg_req.wdata[VALUE_W-1:0];
            default: ;
          endcase
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcfg_r[0]    <= '0;
      pcfg_r[1]    <= '0;
      max_dev_r[0] <= 16'h0000;
      max_dev_r[1] <= 16'h0000;
      timeout_r[0] <= 8'h00;
      timeout_r[1] <= 8'h00;
    end else if (reg_req.wr) begin
      case (addr)
        REG_PAIR_CFG: begin
          pcfg_r[0] <= pair_cfg_type'(reg_req.wdata[PAIR_CFG_W-1:0]);
          pcfg_r[1] <= pair_cfg_type'(reg_req.wdata[PAIR_BYTE+PAIR_CFG_W-1:PAIR_BYTE]);
        end
        REG_MAX_DEV0: max_dev_r[0] <= reg_req.wdata[VALUE_W-1:0];
        REG_MAX_DEV1: max_dev_r[1] <= reg_req.wdata[VALUE_W-1:0];
        REG_TIMEOUT0: timeout_r[0] <= reg_req.wdata[SEC_W-1:0];
        REG_TIMEOUT1: timeout_r[1] <= reg_req.wdata[SEC_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // sample capture with anomaly saturation
  logic [SAMPLE_W-1:0] code_r    [LANES];
  logic [LANES-1:0]    anomaly_r;

  generate
    for (gl = 0; gl < LANES; gl++) begin : g_capture
      wire logic [SAMPLE_W-1:0] sat_code = cfg_r[gl].sat_high ? CODE_25MA : CODE_0MA;
      wire logic [SAMPLE_W-1:0] code_nxt =
        sensor_anomaly[gl] ? sat_code :                                     // R23
        sample_valid[gl]   ? sample_code[gl*SAMPLE_W +: SAMPLE_W] : code_r[gl];
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          code_r[gl]    <= 16'h0000;
          anomaly_r[gl] <= 1'b0;
        end else begin
          code_r[gl]    <= code_nxt;
          anomaly_r[gl] <= sensor_anomaly[gl];
        end
      end
    end
  endgenerate

  // ==========================================================
  // scaling; odd lane of a redundant pair borrows the even lane's scale unless different
  logic signed [VALUE_W-1:0] eng_r [LANES];

  generate
    for (gl = 0; gl < LANES; gl++) begin : g_scale
      localparam int SL = (gl % 2 == 1) ? gl - 1 : gl;
      wire logic share = (gl % 2 == 1) && pcfg_r[gl/2].redundant && !pcfg_r[gl/2].diff;
      wire logic signed [VALUE_W-1:0] use_min = share ? smin_r[SL] : smin_r[gl]; // R6 R7
      wire logic signed [VALUE_W-1:0] use_max = share ? smax_r[SL] : smax_r[gl]; // R6 R7
      wire logic [1:0] use_typ = share ? cfg_r[SL].sensor : cfg_r[gl].sensor;
      wire logic signed [VALUE_W-1:0] eng_nxt = scale_fn(code_r[gl], use_typ, use_min, use_max);
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) eng_r[gl] <= 16'h0000;
        else        eng_r[gl] <= eng_nxt;
      end
    end
  endgenerate

  // ==========================================================
  // pair consolidation and coherence
  logic signed [VALUE_W-1:0] lane_val [LANES];
  logic [SEC_W-1:0]          sec_r    [PAIRS];
  logic [31:0]               pre_r    [PAIRS];
  logic [PAIRS-1:0]          fault_r;

  genvar gp;
  generate
    for (gp = 0; gp < PAIRS; gp++) begin : g_pair
      wire logic signed [VALUE_W-1:0] va = eng_r[2*gp];
      wire logic signed [VALUE_W-1:0] vb = eng_r[2*gp+1];
      wire logic signed [VALUE_W:0]   sum  = {va[VALUE_W-1], va} + {vb[VALUE_W-1], vb};
      wire logic signed [VALUE_W:0]   diff = {va[VALUE_W-1], va} - {vb[VALUE_W-1], vb};
      wire logic [VALUE_W:0]          adiff = diff[VALUE_W] ? -diff : diff;
      wire logic signed [VALUE_W-1:0] avg  = VALUE_W'(sum >>> 1);
      wire logic over = pcfg_r[gp].redundant && (adiff > {1'b0, max_dev_r[gp]}); // R3
      wire logic sec_end = (pre_r[gp] == 32'(CYCLES_PER_SEC - 1));
      wire logic expired = (sec_r[gp] > timeout_r[gp]) ||
                           ((sec_r[gp] == timeout_r[gp]) && (pre_r[gp] != 32'h0)); // R4
      logic signed [VALUE_W-1:0] cons_val;
      always_comb begin
        case (consolidation_type'(pcfg_r[gp].cons))
          CONS_PRIMARY:   cons_val = va;                                   // R8
          CONS_REDUNDANT: cons_val = vb;                                   // R9
          CONS_MAX:       cons_val = (va > vb) ? va : vb;                  // R10
          CONS_MIN:       cons_val = (va < vb) ? va : vb;                  // R11
          CONS_AVERAGE:   cons_val = avg;                                  // R12
          default:        cons_val = va;
        endcase
      end
      assign lane_val[2*gp]   = pcfg_r[gp].redundant ? cons_val : va;      // R2 R1
      assign lane_val[2*gp+1] = vb;
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          pre_r[gp]   <= 32'h0;
          sec_r[gp]   <= 8'h00;
          fault_r[gp] <= 1'b0;
        end else if (!over) begin
          pre_r[gp]   <= 32'h0;                                            // R5
          sec_r[gp]   <= 8'h00;
          fault_r[gp] <= 1'b0;
        end else begin
          pre_r[gp]   <= sec_end ? 32'h0 : pre_r[gp] + 32'h1;
          if (sec_end && sec_r[gp] != 8'hFF) sec_r[gp] <= sec_r[gp] + 8'h01;
          fault_r[gp] <= expired;                                          // R5
        end
      end
    end
  endgenerate

  // ==========================================================
  // comparators; the redundant lane of a pair is parked
  window_state_type win_r [LANES];
  logic [LANES-1:0] t1_r;
  logic [LANES-1:0] t2_r;
  logic [LANES-1:0] active;

  generate
    for (gl = 0; gl < LANES; gl++) begin : g_cmp
      wire logic signed [VALUE_W:0] v   = {lane_val[gl][VALUE_W-1], lane_val[gl]};
      wire logic signed [VALUE_W:0] hi  = {thr_hi_r[gl][VALUE_W-1], thr_hi_r[gl]};
      wire logic signed [VALUE_W:0] lo  = {thr_lo_r[gl][VALUE_W-1], thr_lo_r[gl]};
      wire logic signed [VALUE_W:0] hy  = {hyst_r[gl][VALUE_W-1], hyst_r[gl]};
      // entry band inside stay band: no toggling
      wire logic enter = (v < hi - hy) && (v > lo + hy);                   // R21
      wire logic stay  = (v < hi) && (v > lo + hy);                        // R22
      assign active[gl] = !((gl % 2 == 1) && pcfg_r[gl/2].redundant);
      window_state_type win_nxt;
      always_comb begin
        case (win_r[gl])                                                   // R18
          WIN_OUT: win_nxt = enter ? WIN_IN : WIN_OUT;
          WIN_IN:  win_nxt = stay ? WIN_IN : WIN_OUT;
          default: win_nxt = WIN_OUT;
        endcase
        if (!cfg_r[gl].win_en || !active[gl]) win_nxt = WIN_OUT;
      end
      // a threshold goes over above it and back under below it minus hysteresis
      wire logic t1_nxt = cfg_r[gl].thr1_en && active[gl] &&
                          (t1_r[gl] ? !(v < hi - hy) : (v > hi));
      wire logic t2_nxt = cfg_r[gl].thr2_en && active[gl] &&
                          (t2_r[gl] ? !(v < lo - hy) : (v > lo));
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          win_r[gl] <= WIN_OUT;
          t1_r[gl]  <= 1'b0;
          t2_r[gl]  <= 1'b0;
        end else begin
          win_r[gl] <= win_nxt;
          t1_r[gl]  <= t1_nxt;
          t2_r[gl]  <= t2_nxt;
        end
      end
    end
  endgenerate

  // ==========================================================
  // registered outputs
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_out
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          measurement_value[gl*VALUE_W +: VALUE_W] <= 16'h0000;
          comparator_result_output[gl]             <= 1'b0;
          threshold2_output[gl]                    <= 1'b0;
          error_output[gl]                         <= 1'b0;
        end else begin
          measurement_value[gl*VALUE_W +: VALUE_W] <= lane_val[gl];       // R12
          comparator_result_output[gl] <= cfg_r[gl].win_en ?
                                          (win_r[gl] == WIN_IN) : t1_r[gl]; // R17 R19 R20 R16
          threshold2_output[gl] <= cfg_r[gl].win_en ? 1'b0 : t2_r[gl];    // R16
          error_output[gl]      <= cfg_r[gl].err_en && anomaly_r[gl];     // R24
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) coherence_fault <= '0;
    else        coherence_fault <= fault_r;
  end

  // ==========================================================
  // read port, data in the cycle after the strobe
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr < REG_PAIR_CFG) begin
      case (ofs)
        OFS_CFG:       rd_mux = 32'(cfg_r[addr[4:3]]);
        OFS_SCALE_MIN: rd_mux = 32'(smin_r[addr[4:3]]);
        OFS_SCALE_MAX: rd_mux = 32'(smax_r[addr[4:3]]);
        OFS_THR_HI:    rd_mux = 32'(thr_hi_r[addr[4:3]]);
        OFS_THR_LO:    rd_mux = 32'(thr_lo_r[addr[4:3]]);
        OFS_HYST:      rd_mux = 32'(hyst_r[addr[4:3]]);
        OFS_VALUE:     rd_mux = 32'(measurement_value[addr[4:3]*VALUE_W +: VALUE_W]);
        default:       rd_mux = 32'h0000_0000;
      endcase
    end else begin
      case (addr)
        REG_PAIR_CFG: rd_mux = {16'h0000, 3'h0, pcfg_r[1], 3'h0, pcfg_r[0]};
        REG_MAX_DEV0: rd_mux = 32'(max_dev_r[0]);
        REG_MAX_DEV1: rd_mux = 32'(max_dev_r[1]);
        REG_TIMEOUT0: rd_mux = 32'(timeout_r[0]);
        REG_TIMEOUT1: rd_mux = 32'(timeout_r[1]);
        REG_STATUS:   rd_mux = {14'h0, coherence_fault, error_output,
                                threshold2_output, comparator_result_output, anomaly_r};
        default:      rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)          rd_data <= 32'h0000_0000;
    else if (reg_req.rd) rd_data <= rd_mux;
    else                 rd_data <= 32'h0000_0000;
  end

endmodule // analog_input_block

`default_nettype wire

// ===== design/analog_input_pkg.sv
// shared constants, types and register map of the analog input processing block
package analog_input_pkg;

  // ==========================================================
  // sizes
  localparam int LANES    = 4;
  localparam int PAIRS    = 2;
  localparam int SAMPLE_W = 16;
  localparam int VALUE_W  = 16;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int SEC_W    = 8;

  // ==========================================================
  // converter codes: 1 mA = 0x0400, 10 V full scale equals 20 mA code
  localparam logic [SAMPLE_W-1:0] CODE_0MA  = 16'h0000;
  localparam logic [SAMPLE_W-1:0] CODE_4MA  = 16'h1000;
  localparam logic [SAMPLE_W-1:0] CODE_20MA = 16'h5000;
  localparam logic [SAMPLE_W-1:0] CODE_25MA = 16'h6400;
  localparam logic [SAMPLE_W-1:0] CODE_0V   = 16'h0000;
  localparam logic [SAMPLE_W-1:0] CODE_10V  = 16'h5000;
  // reciprocal of the code span, scaled by 2^RECIP_SH
  localparam int                  RECIP_SH   = 30;
  localparam logic [17:0]         RECIP_4_20 = 18'h10000;
  localparam logic [17:0]         RECIP_0_20 = 18'h0CCCD;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 40000000;
  localparam int SEC_S  = 1;

  // ==========================================================
  // register map, word indexes
  localparam logic [ADDR_W-1:0] LANE_STRIDE  = 8'h08;
  localparam logic [2:0] OFS_CFG        = 3'h0;
  localparam logic [2:0] OFS_SCALE_MIN  = 3'h1;
  localparam logic [2:0] OFS_SCALE_MAX  = 3'h2;
  localparam logic [2:0] OFS_THR_HI     = 3'h3;
  localparam logic [2:0] OFS_THR_LO     = 3'h4;
  localparam logic [2:0] OFS_HYST       = 3'h5;
  localparam logic [2:0] OFS_VALUE      = 3'h6;
  localparam logic [ADDR_W-1:0] REG_PAIR_CFG = 8'h20;
  localparam logic [ADDR_W-1:0] REG_MAX_DEV0 = 8'h21;
  localparam logic [ADDR_W-1:0] REG_MAX_DEV1 = 8'h22;
  localparam logic [ADDR_W-1:0] REG_TIMEOUT0 = 8'h23;
  localparam logic [ADDR_W-1:0] REG_TIMEOUT1 = 8'h24;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h25;

  // ==========================================================
  // field layouts and enumerations
  typedef enum logic [1:0] {
    SENS_4_20 = 2'h0,
    SENS_0_20 = 2'h1,
    SENS_0_10V = 2'h2
  } sensor_type;

  typedef enum logic [2:0] {
    CONS_PRIMARY   = 3'h0,
    CONS_REDUNDANT = 3'h1,
    CONS_MAX       = 3'h2,
    CONS_MIN       = 3'h3,
    CONS_AVERAGE   = 3'h4
  } consolidation_type;

  typedef enum logic [1:0] {
    WIN_OUT = 2'b01,
    WIN_IN  = 2'b10
  } window_state_type;

  // lane CFG word: [1:0] sensor, [2] window, [3] thr1, [4] thr2, [5] sat 25 mA, [6] error out
  typedef struct packed {
    logic       err_en;
    logic       sat_high;
    logic       thr2_en;
    logic       thr1_en;
    logic       win_en;
    logic [1:0] sensor;
  } lane_cfg_type;
  localparam int LANE_CFG_W = 7;
  localparam lane_cfg_type LANE_CFG_RST = 7'h00;

  // PAIR_CFG byte per pair: [0] redundant, [1] different sensors, [4:2] consolidation
  typedef struct packed {
    logic [2:0] cons;
    logic       diff;
    logic       redundant;
  } pair_cfg_type;
  localparam int PAIR_CFG_W = 5;
  localparam int PAIR_BYTE  = 8;

  // register port bundle
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_type;

endpackage

// ===== sim/analog_input_block_test.sv
// self-checking bench for the analog input processing block
`timescale 1ns/1ps
`default_nettype none
module analog_input_block_test
  import analog_input_pkg::*;
;
  typedef struct {string name; logic [31:0] exp; logic [31:0] mask;} note_type;
  logic                      sys_clk = 1'b0;
  logic                      rst_n = 1'b0;
  reg_req_type               req = '0;
  logic [DATA_W-1:0]         rd_data;
  logic [LANES-1:0]          valid, anomaly, cmp, thr2, err;
  logic [LANES-1:0]          fault = '0;
  logic [LANES*SAMPLE_W-1:0] code;
  logic [LANES*SAMPLE_W-1:0] level = '0;
  logic [LANES*VALUE_W-1:0]  meas;
  logic [PAIRS-1:0]          coh;
  logic                      slow = 1'b0;
  logic                      rd_prev = 1'b0;
  logic [31:0]               lf = 32'hD611888C;
  logic [15:0]               c;
  int                        error_cnt = 0;
  int                        samples_checked = 0;
  note_type                  notes[$];
  note_type                  nt;
  logic [7:0] cfg_a[12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h0A, 8'h10, 8'h11,
                            8'h12, REG_MAX_DEV0, REG_TIMEOUT0};
  int cfg_d[12] = '{'h64, 0, 1600, 1000, 200, 100, 3200, 'h5A, 100, 1000, 300, 1};
  int wv[7] = '{850, 950, 1000, 950, 350, 300, 200};
  int wo[7] = '{1, 1, 0, 0, 1, 0, 0};
  int cv[5] = '{800, 400, 800, 400, 600};

  always #12.5 sys_clk = ~sys_clk;

  sensor_front_end u_fe (.sys_clk(sys_clk), .rst_n(rst_n), .level_code(level), .fault(fault),
    .slow(slow), .sample_valid(valid), .sample_code(code), .sensor_anomaly(anomaly));
  analog_input_block #(.CYCLES_PER_SEC(10)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_req(req), .rd_data(rd_data), .sample_valid(valid), .sample_code(code),
    .sensor_anomaly(anomaly), .measurement_value(meas), .comparator_result_output(cmp),
    .threshold2_output(thr2), .error_output(err), .coherence_fault(coh));

  // ==========================================================
  // helpers
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // 4-20 mA code for a value on the 0..1600 lane scale
  function automatic logic [15:0] c4(input int v);
    return 16'(32'h1000 + v * 1024 / 100);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m);
    @(posedge sys_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    notes.push_back('{n, e & m, m});
    @(posedge sys_clk);
    req.rd <= 1'b0;
  endtask
  task automatic put(input int ln, input logic [15:0] v, input int w);
    level[ln*16 +: 16] <= v;
    repeat (w) @(posedge sys_clk);
  endtask
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // read answers stand only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_prev && notes.size() > 0) begin
      nt = notes.pop_front();
      check(nt.name, rd_data & nt.mask, nt.exp);
    end
    rd_prev <= req.rd;
  end

  // ==========================================================
  // scenarios
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (cfg_a[i]) wr(cfg_a[i], cfg_d[i]);
    put(0, 16'h1000, 20);
    rd_chk("lane0 value", 8'h06, 0, 32'hFFFF);
    put(0, 16'h5000, 20);
    rd_chk("lane0 value", 8'h06, 1600, 32'hFFFF);
    put(2, 16'h5000, 20);
    rd_chk("lane2 value", 8'h16, 1000, 32'hFFFF);
    rd_chk("thresholds", REG_STATUS, 32'h440, 32'h440);
    rd_chk("lane0 value", 8'h06, 1600, 32'hFFFF);
    foreach (wv[i]) begin
      put(0, c4(wv[i]), 20);
      rd_chk("window output", REG_STATUS, 32'(wo[i] << 4), 32'h10);
    end
    slow <= 1'b1;
    repeat (4) begin
      lf = next_rand(lf);
      c = 16'(lf % 32'h5001);
      put(2, c, 20);
      rd_chk("lane2 value", 8'h16, 32'(100 + ((64'(c) * 900 * 52429) >> 30)), 32'hFFFF);
    end
    fault <= 4'h5;
    repeat (20) @(posedge sys_clk);
    rd_chk("lane0 saturated", 8'h06, 2100, 32'hFFFF);
    rd_chk("lane2 saturated", 8'h16, 100, 32'hFFFF);
    rd_chk("error outputs", REG_STATUS, 32'h5000, 32'hF000);
    fault <= 4'h0;
    repeat (8) @(posedge sys_clk);
    rd_chk("error outputs", REG_STATUS, 0, 32'hF000);
    put(0, 16'h3000, 0);
    put(1, 16'h2000, 20);
    foreach (cv[i]) begin
      wr(REG_PAIR_CFG, 32'(1 + 4 * i));
      repeat (20) @(posedge sys_clk);
      rd_chk("consolidated", 8'h06, cv[i], 32'hFFFF);
    end
    rd_chk("coherence", REG_STATUS, 32'h10000, 32'h10000);
    put(1, 16'h2800, 20);
    rd_chk("coherence", REG_STATUS, 0, 32'h10000);
    put(1, 16'h2000, 8);
    rd_chk("coherence", REG_STATUS, 0, 32'h10000);
    repeat (25) @(posedge sys_clk);
    rd_chk("coherence", REG_STATUS, 32'h10000, 32'h10000);
    put(1, 16'h1800, 0);
    wr(REG_PAIR_CFG, 32'h5);
    repeat (20) @(posedge sys_clk);
    rd_chk("equal scale", 8'h06, 200, 32'hFFFF);
    wr(REG_PAIR_CFG, 32'h7);
    repeat (20) @(posedge sys_clk);
    rd_chk("own scale", 8'h06, 400, 32'hFFFF);
    repeat (2) @(posedge sys_clk);
    end_of_test();
  end

  // the sequence needs about 630 cycles; 20000 leaves ample margin
  initial begin
    #500000;
    error_cnt++;
    end_of_test();
  end
endmodule // analog_input_block_test
`default_nettype wire

// ===== sim/analog_input_properties.sv
// concurrent checks on the ports of the analog input processing block
`timescale 1ns/1ps
`default_nettype none
module analog_input_properties
  import analog_input_pkg::*;
#(
  parameter int CYCLES_PER_SEC = 10
) (
  input wire logic                      sys_clk,
  input wire logic                      rst_n,
  input wire reg_req_type               reg_req,
  input wire logic [DATA_W-1:0]         rd_data,
  input wire logic [LANES-1:0]          sample_valid,
  input wire logic [LANES*SAMPLE_W-1:0] sample_code,
  input wire logic [LANES-1:0]          sensor_anomaly,
  input wire logic [LANES*VALUE_W-1:0]  measurement_value,
  input wire logic [LANES-1:0]          comparator_result_output,
  input wire logic [LANES-1:0]          threshold2_output,
  input wire logic [LANES-1:0]          error_output,
  input wire logic [PAIRS-1:0]          coherence_fault
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // register port
  a_read_idle_zero: assert property (!$past(reg_req.rd) |-> rd_data == '0)
    else $error("read data not zero outside read answer");
  a_unmapped_read: assert property (reg_req.rd && reg_req.addr > REG_STATUS |=> rd_data == '0)
    else $error("unmapped read not zero");
  a_status_error: assert property (reg_req.rd && reg_req.addr == REG_STATUS |=>
    rd_data[31:18] == '0 && rd_data[15:12] == $past(error_output)
    && rd_data[17:16] == $past(coherence_fault)) else $error("status error bits wrong");
  a_status_cmp: assert property (reg_req.rd && reg_req.addr == REG_STATUS |=>
    rd_data[7:4] == $past(comparator_result_output) && rd_data[11:8] == $past(threshold2_output))
    else $error("status comparator bits wrong");
  a_value_readback: assert property (reg_req.rd && reg_req.addr == 8'h06 |=>
    rd_data[15:0] == $past(measurement_value[15:0])) else $error("value readback wrong");

  // ==========================================================
  // error output, two cycles behind the anomaly
  a_error_cause: assert property ((error_output & ~$past(sensor_anomaly, 2)) == '0)
    else $error("error output without anomaly");
  a_error_holds: assert property (!$past(reg_req.wr) && !$past(reg_req.wr, 2) |->
    (($past(error_output) & $past(sensor_anomaly, 2)) & ~error_output) == '0)
    else $error("error output dropped while anomaly present");

  // ==========================================================
  // quiet inputs leave results untouched
  a_value_quiet: assert property ((sample_valid == '0 && sensor_anomaly == '0 && !reg_req.wr)[*6]
    |=> $stable(measurement_value)) else $error("value moved without samples");
  a_cmp_quiet: assert property ((sample_valid == '0 && sensor_anomaly == '0 && !reg_req.wr)[*7]
    |=> $stable(comparator_result_output) && $stable(threshold2_output))
    else $error("comparator moved without samples");
endmodule // analog_input_properties

bind analog_input_block analog_input_properties #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .rd_data(rd_data),
  .sample_valid(sample_valid), .sample_code(sample_code), .sensor_anomaly(sensor_anomaly),
  .measurement_value(measurement_value), .comparator_result_output(comparator_result_output),
  .threshold2_output(threshold2_output), .error_output(error_output),
  .coherence_fault(coherence_fault));
`default_nettype wire

// ===== sim/sensor_front_end.sv
// converter front end model feeding lane samples
`timescale 1ns/1ps
`default_nettype none
module sensor_front_end
  import analog_input_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic [LANES*SAMPLE_W-1:0] level_code,
  input  wire logic [LANES-1:0]          fault,
  input  wire logic                      slow,
  output logic      [LANES-1:0]          sample_valid,
  output logic      [LANES*SAMPLE_W-1:0] sample_code,
  output logic      [LANES-1:0]          sensor_anomaly
);
  logic [2:0] phase_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= '0;
      sample_valid <= '0;
      sample_code <= '0;
      sensor_anomaly <= '0;
    end else begin
      phase_r <= phase_r + 3'h1;
      sensor_anomaly <= fault;
      // slow converter: one sample in eight, stale code inverted so it is never trusted
      if (!slow || phase_r == 3'h0) begin
        sample_valid <= '1;
        sample_code <= level_code;
      end else begin
        sample_valid <= '0;
        sample_code <= ~sample_code;
      end
    end
  end
endmodule // sensor_front_end
`default_nettype wire
